// File: hw/pccs_regs.sv
`timescale 1ns/1ps
`include "pccs_map.svh"


module pccs_regs #(
  parameter int NUM_FIELDS = `PCCS_NUM_FIELDS
) (
  input  wire logic                   clock_i,
  input  wire logic                   reset_i,
  input  wire pccs_pkg::pccs_bus_req_t bus_i,
  output logic [15:0]                 rdata_o,
  input  wire pccs_pkg::pccs_events_t events_i,
  output pccs_pkg::pccs_time_t        sync_time_o,
  output logic                        clock_running_o,
  output logic                        clock_logic_reset_o,
  output logic                        irq_o
);

  localparam logic [31:0] NS_PER_SEC = 32'(`PCCS_NS_PER_SEC);
  localparam logic [31:0] TICK_NS    = 32'(`PCCS_CLK_PERIOD_NS);
  localparam int          IDX_W      = $clog2(NUM_FIELDS + 1);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(NUM_FIELDS);

  // ==========================================================
  // Helpers
  // ==========================================================
  // Adds two times, carrying nanosecond overflow into seconds.
  // Both operands are assumed normalised below one second.
  function automatic pccs_pkg::pccs_time_t time_add(input pccs_pkg::pccs_time_t a,
                                                    input pccs_pkg::pccs_time_t b);
    pccs_pkg::pccs_time_t r;
    logic [32:0]          ns_sum;
    ns_sum = {1'b0, a.ns} + {1'b0, b.ns};
    r.sec  = a.sec + b.sec;
    if (ns_sum >= {1'b0, NS_PER_SEC})
    begin
      ns_sum = ns_sum - {1'b0, NS_PER_SEC};
      r.sec  = r.sec + 32'h0000_0001;
    end
    r.ns = ns_sum[31:0];
    return r;
  endfunction : time_add

  function automatic logic [15:0] field_of(input pccs_pkg::pccs_time_t t, input logic [IDX_W-1:0] i);
    logic [63:0] flat;
    flat = {t.sec, t.ns};
    if (i < LAST_IDX)
      return flat[16*i +: 16];
    return 16'h0000;
  endfunction : field_of

  // ==========================================================
  // Decode
  // ==========================================================
  logic wr_ctl;
  logic wr_tdp;
  logic wr_sts;
  logic rd_ctl;
  logic rd_tdp;
  logic rd_sts;

  assign wr_ctl = bus_i.wr && (bus_i.addr == `PCCS_CTL_OFS);
  assign wr_tdp = bus_i.wr && (bus_i.addr == `PCCS_TDP_OFS);
  assign wr_sts = bus_i.wr && (bus_i.addr == `PCCS_STS_OFS);
  assign rd_ctl = bus_i.rd && (bus_i.addr == `PCCS_CTL_OFS);
  assign rd_tdp = bus_i.rd && (bus_i.addr == `PCCS_TDP_OFS);
  assign rd_sts = bus_i.rd && (bus_i.addr == `PCCS_STS_OFS);

  logic cmd_load;
  logic cmd_step;
  logic cmd_on;
  logic cmd_off;
  logic cmd_capture;

  assign cmd_load    = wr_ctl && bus_i.wdata[`PCCS_LOAD_BIT];
  assign cmd_step    = wr_ctl && bus_i.wdata[`PCCS_STEP_BIT];
  assign cmd_on      = wr_ctl && bus_i.wdata[`PCCS_RUN_ON_BIT];
  assign cmd_off     = wr_ctl && bus_i.wdata[`PCCS_RUN_OFF_BIT];
  assign cmd_capture = wr_ctl && bus_i.wdata[`PCCS_CAPTURE_BIT];

  // ==========================================================
  // Soft reset
  // ==========================================================
  logic clock_soft_reset;
  logic sync_rst;

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      clock_soft_reset <= 1'b0;
    else if (wr_ctl)
      clock_soft_reset <= bus_i.wdata[`PCCS_SRST_BIT];
  end

  assign sync_rst            = reset_i || clock_soft_reset;
  assign clock_logic_reset_o = clock_soft_reset;

  // ==========================================================
  // Clock run state
  // ==========================================================
  logic clock_run;

  always_ff @(posedge clock_i)
  begin
    if (sync_rst)
      clock_run <= 1'b0;
    else if (cmd_off)
      clock_run <= 1'b0;
    else if (cmd_on)
      clock_run <= 1'b1;
  end

  assign clock_running_o = clock_run;

  // ==========================================================
  // Time-data port buffers and sequence counters
  // ==========================================================
  logic [63:0]          wr_buf;
  logic [IDX_W-1:0]     wr_idx;
  logic [IDX_W-1:0]     rd_idx;
  pccs_pkg::pccs_time_t captured;
  pccs_pkg::pccs_time_t wr_time;

  assign wr_time = pccs_pkg::pccs_time_t'(wr_buf);

  always_ff @(posedge clock_i)
  begin
    if (sync_rst)
    begin
      wr_buf <= 64'h0000_0000_0000_0000;
      wr_idx <= '0;
    end
    // Load or step restarts write sequence
    else if (cmd_load || cmd_step)
      wr_idx <= '0;
    else if (wr_tdp && (wr_idx < LAST_IDX))
    begin
      wr_buf[16*wr_idx +: 16] <= bus_i.wdata;
      wr_idx                  <= wr_idx + IDX_W'(1);
    end
  end

  // ==========================================================
  // Running time
  // ==========================================================
  pccs_pkg::pccs_time_t sync_time;
  pccs_pkg::pccs_time_t tick;

  assign tick = '{sec: 32'h0000_0000, ns: TICK_NS};

  always_ff @(posedge clock_i)
  begin
    if (sync_rst)
      sync_time <= '0;
    else if (cmd_load)
      sync_time <= wr_time;
    else if (cmd_step)
      sync_time <= time_add(sync_time, wr_time);
    else if (clock_run)
      sync_time <= time_add(sync_time, tick);
  end

  assign sync_time_o = sync_time;

  // Sampling in one cycle keeps the seconds and nanoseconds of a
  // readout consistent even while the clock keeps running.
  always_ff @(posedge clock_i)
  begin
    if (sync_rst)
    begin
      captured <= '0;
      rd_idx   <= LAST_IDX;
    end
    else if (cmd_capture)
    begin
      captured <= sync_time;
      rd_idx   <= '0;
    end
    else if (rd_tdp && (rd_idx < LAST_IDX))
      rd_idx <= rd_idx + IDX_W'(1);
  end

  // ==========================================================
  // Status and interrupt enables
  // ==========================================================
  logic [3:0] irq_enable;
  logic       trigger_finished_flag;
  logic       tx_stamp_ready;
  logic       rx_stamp_ready;
  logic       event_stamp_ready;

  always_ff @(posedge clock_i)
  begin
    if (sync_rst)
      irq_enable <= `PCCS_IE_RST;
    else if (wr_sts)
      irq_enable <= bus_i.wdata[`PCCS_TX_IE_BIT:`PCCS_EVT_IE_BIT];
  end

  // Set on fire with notify, clear on status read, set wins
  always_ff @(posedge clock_i)
  begin
    if (sync_rst)
      trigger_finished_flag <= 1'b0;
    else if (events_i.trig_fired && events_i.trig_notify)
      trigger_finished_flag <= 1'b1;
    else if (rd_sts)
      trigger_finished_flag <= 1'b0;
  end

  // Stamp engines own the queues; the flag follows their pending level outside soft reset
  // Tx, Rx and event pending levels
  assign tx_stamp_ready    = events_i.tx_pending && !clock_soft_reset;
  assign rx_stamp_ready    = events_i.rx_pending && !clock_soft_reset;
  assign event_stamp_ready = events_i.event_pending && !clock_soft_reset;

  logic [15:0] status_word;

  always_comb
  begin
    status_word                      = 16'h0000;
    status_word[`PCCS_TX_RDY_BIT]    = tx_stamp_ready;
    status_word[`PCCS_RX_RDY_BIT]    = rx_stamp_ready;
    status_word[`PCCS_TRIGGER_FINISHED_FLAG_BIT] = trigger_finished_flag;
    status_word[`PCCS_EVT_RDY_BIT]   = event_stamp_ready;
    status_word[`PCCS_TX_IE_BIT:`PCCS_EVT_IE_BIT] = irq_enable;
  end

  always_ff @(posedge clock_i)
  begin
    if (sync_rst)
      irq_o <= 1'b0;
    else
      irq_o <= |(status_word[`PCCS_TX_RDY_BIT:`PCCS_EVT_RDY_BIT] & irq_enable);
  end

  // ==========================================================
  // Read data
  // ==========================================================
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      rdata_o <= 16'h0000;
    else if (rd_ctl)
    begin
      rdata_o                   <= `PCCS_CTL_RST;
      rdata_o[`PCCS_RUN_ON_BIT] <= clock_run;
      rdata_o[`PCCS_SRST_BIT]   <= clock_soft_reset;
    end
    else if (rd_tdp)
      rdata_o <= field_of(captured, rd_idx);
    else if (rd_sts)
      rdata_o <= status_word;
    else
      rdata_o <= 16'h0000;
  end

  // ==========================================================
  // Checks
  // ==========================================================
  sequence load_issued_s;
    cmd_load && !sync_rst;
  endsequence

  sequence step_issued_s;
    cmd_step && !cmd_load && !sync_rst;
  endsequence

  // A stopped clock only moves by load, step or reset
  sequence clock_halted_s;
    !clock_run && !cmd_load && !cmd_step;
  endsequence

  clock_load_a : assert property (@(posedge clock_i) disable iff (reset_i)
    load_issued_s |=> (sync_time == $past(wr_time)) || clock_soft_reset)
    else $error("load did not take written time");

  clock_step_a : assert property (@(posedge clock_i) disable iff (reset_i)
    step_issued_s |=> (sync_time == time_add($past(sync_time), $past(wr_time))) || clock_soft_reset)
    else $error("step did not add offset");

  ctl_readback_a : assert property (@(posedge clock_i) disable iff (reset_i)
    rd_ctl |=> (rdata_o[`PCCS_CAPTURE_BIT:`PCCS_STEP_BIT] == 3'h0) && !rdata_o[`PCCS_RUN_OFF_BIT])
    else $error("command bit read back nonzero");

  run_on_a : assert property (@(posedge clock_i) disable iff (reset_i)
    cmd_on && !cmd_off && !sync_rst |=> clock_run)
    else $error("enable did not start clock");

  run_state_a : assert property (@(posedge clock_i) disable iff (reset_i)
    rd_ctl |=> rdata_o[`PCCS_RUN_ON_BIT] == $past(clock_run))
    else $error("enable state not reported");

  run_off_a : assert property (@(posedge clock_i) disable iff (reset_i)
    cmd_off |=> !clock_run)
    else $error("disable did not stop clock");

  clock_still_a : assert property (@(posedge clock_i) disable iff (sync_rst)
    clock_halted_s |=> $stable(sync_time))
    else $error("stopped clock moved");

  soft_reset_a : assert property (@(posedge clock_i) disable iff (reset_i)
    clock_soft_reset |=> !clock_run && (sync_time == '0) && (irq_enable == 4'h0) && !irq_o)
    else $error("soft reset did not hold state");

  soft_hold_a : assert property (@(posedge clock_i) disable iff (reset_i)
    clock_soft_reset && !wr_ctl |=> clock_soft_reset)
    else $error("soft reset cleared itself");

  read_beyond_a : assert property (@(posedge clock_i) disable iff (sync_rst)
    rd_tdp && (rd_idx == LAST_IDX) |=> rdata_o == 16'h0000)
    else $error("read past last field nonzero");

  trig_set_a : assert property (@(posedge clock_i) disable iff (sync_rst)
    events_i.trig_fired && events_i.trig_notify |=> trigger_finished_flag)
    else $error("trigger done lost");

  trig_clear_a : assert property (@(posedge clock_i) disable iff (sync_rst)
    rd_sts && !(events_i.trig_fired && events_i.trig_notify) |=> !trigger_finished_flag)
    else $error("trigger done not cleared by read");

  trig_gate_a : assert property (@(posedge clock_i) disable iff (sync_rst)
    !trigger_finished_flag && !(events_i.trig_fired && events_i.trig_notify) |=> !trigger_finished_flag)
    else $error("trigger done set without notify");

  sts_reserved_a : assert property (@(posedge clock_i) disable iff (reset_i)
    rd_sts |=> (rdata_o[15:12] == 4'h0) && (rdata_o[7:4] == 4'h0))
    else $error("reserved status bits nonzero");

  irq_gate_a : assert property (@(posedge clock_i) disable iff (sync_rst)
    ##1 irq_o == $past(|(status_word[`PCCS_TX_RDY_BIT:`PCCS_EVT_RDY_BIT] & irq_enable)))
    else $error("interrupt does not follow flags");

  seq_restart_a : assert property (@(posedge clock_i) disable iff (sync_rst)
    cmd_capture |=> (rd_idx == '0) and (rd_tdp |=> rdata_o == captured.ns[15:0]))
    else $error("capture did not restart sequence");

endmodule : pccs_regs

// File: hw/pccs_map.svh
`ifndef PCCS_MAP_SVH
`define PCCS_MAP_SVH

// Register offsets (word index on the register port)
`define PCCS_CTL_OFS        5'h14
`define PCCS_TDP_OFS        5'h15
`define PCCS_STS_OFS        5'h16

// Control register bit positions
`define PCCS_CAPTURE_BIT    5
`define PCCS_LOAD_BIT       4
`define PCCS_STEP_BIT       3
`define PCCS_RUN_ON_BIT     2
`define PCCS_RUN_OFF_BIT    1
`define PCCS_SRST_BIT       0

// Status register bit positions
`define PCCS_TX_RDY_BIT     11
`define PCCS_RX_RDY_BIT     10
`define PCCS_TRIGGER_FINISHED_FLAG_BIT  9
`define PCCS_EVT_RDY_BIT    8
`define PCCS_TX_IE_BIT      3
`define PCCS_RX_IE_BIT      2
`define PCCS_TRIGGER_IRQ_ON_BIT    1
`define PCCS_EVT_IE_BIT     0

// Reset values
`define PCCS_CTL_RST        16'h0000
`define PCCS_IE_RST         4'h0

// Timing: clock period in ns and nanoseconds per second
`define PCCS_CLK_PERIOD_NS  8
`define PCCS_NS_PER_SEC     1000000000

// Time-data port sequence: number of 16-bit fields
`define PCCS_NUM_FIELDS     4

`endif

// File: hw/pccs_pkg.sv
package pccs_pkg;

  typedef struct packed {
    logic [31:0] sec;
    logic [31:0] ns;
  } pccs_time_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } pccs_bus_req_t;

  typedef struct packed {
    logic tx_pending;
    logic rx_pending;
    logic event_pending;
    logic trig_fired;
    logic trig_notify;
  } pccs_events_t;

endpackage : pccs_pkg

// File: bench/pccs_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Management host: one-cycle strobes on the register port
module pccs_host_model (
  input  wire logic               clock_i,
  input  wire logic [15:0]        rdata_i,
  output pccs_pkg::pccs_bus_req_t bus_o
);
  initial bus_o = '0;

  // page four selected
  // The page register sits outside this block, so the model assumes it is set
  task automatic write(input logic [4:0] addr, input logic [15:0] data);
    @(posedge clock_i);
    bus_o <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    bus_o <= '{addr: ~addr, wdata: ~data, wr: 1'b0, rd: 1'b0};
  endtask : write

  // Data is taken at the edge that ends the answer cycle, before it drops
  task automatic read(input logic [4:0] addr, output logic [15:0] data);
    @(posedge clock_i);
    bus_o <= '{addr: addr, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    bus_o <= '{addr: ~addr, wdata: 16'hFFFF, wr: 1'b0, rd: 1'b0};
    @(posedge clock_i);
    data = rdata_i;
  endtask : read
endmodule : pccs_host_model

// File: bench/pccs_regs_bench.sv
`timescale 1ns/1ps
`include "pccs_map.svh"
// ==========================================================
// Register bank bench
module pccs_regs_bench;
  logic                    clock_i = 1'b0;
  logic                    reset_i = 1'b1;
  pccs_pkg::pccs_bus_req_t bus;
  logic [15:0]             rdata;
  pccs_pkg::pccs_events_t  events = '0;
  pccs_pkg::pccs_time_t    sync_time;
  logic                    running;
  logic                    logic_reset;
  logic                    irq;
  logic [15:0]             rd;
  int                      miscompares = 0;
  int                      n_compared = 0;
  int                      cycles = 0;

  always #4 clock_i = ~clock_i;

  pccs_regs #(.NUM_FIELDS(4)) pccs_regs_inst (
    .clock_i(clock_i), .reset_i(reset_i), .bus_i(bus), .rdata_o(rdata), .events_i(events),
    .sync_time_o(sync_time), .clock_running_o(running), .clock_logic_reset_o(logic_reset), .irq_o(irq));
  pccs_host_model pccs_host_model_inst (.clock_i(clock_i), .rdata_i(rdata), .bus_o(bus));

  task automatic check(input logic [71:0] seen, input logic [71:0] expected);
    n_compared++;
    if (seen !== expected)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, expected);
    end
  endtask : check

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    pccs_host_model_inst.write(a, d);
  endtask : wr

  task automatic load_fields(input pccs_pkg::pccs_time_t t);
    wr(`PCCS_TDP_OFS, t.ns[15:0]);
    wr(`PCCS_TDP_OFS, t.ns[31:16]);
    wr(`PCCS_TDP_OFS, t.sec[15:0]);
    wr(`PCCS_TDP_OFS, t.sec[31:16]);
  endtask : load_fields

  task automatic test_reset_state;
    pccs_host_model_inst.read(`PCCS_CTL_OFS, rd);
    check(rd, 64'h0);
    pccs_host_model_inst.read(`PCCS_STS_OFS, rd);
    check(rd, 64'h0);
    pccs_host_model_inst.read(5'h1F, rd);
    check(rd, 64'h0);
    check({running, sync_time}, 65'h0);
  endtask : test_reset_state

  task automatic test_load;
    load_fields('{sec: 32'h1234_5678, ns: 32'h3B9A_C9F6});
    wr(`PCCS_TDP_OFS, 16'hFFFF);
    wr(`PCCS_CTL_OFS, 16'h0010);
    @(posedge clock_i);
    check(sync_time, 64'h1234_5678_3B9A_C9F6);
    pccs_host_model_inst.read(`PCCS_CTL_OFS, rd);
    check(rd, 64'h0);
  endtask : test_load

  task automatic test_step;
    logic [32:0] ns;
    logic [31:0] sec;
    ns = 33'h0_3B9A_C9F6 + 33'h0_0000_0014;
    sec = 32'h1234_5678 + 32'h0000_0001;
    // Nanosecond overflow carries into seconds
    if (ns >= 33'(`PCCS_NS_PER_SEC))
    begin
      ns = ns - 33'(`PCCS_NS_PER_SEC);
      sec = sec + 32'h0000_0001;
    end
    load_fields('{sec: 32'h0000_0001, ns: 32'h0000_0014});
    wr(`PCCS_CTL_OFS, 16'h0008);
    @(posedge clock_i);
    check(sync_time, {sec, ns[31:0]});
  endtask : test_step

  task automatic test_capture;
    pccs_pkg::pccs_time_t t;
    t = sync_time;
    wr(`PCCS_CTL_OFS, 16'h0020);
    pccs_host_model_inst.read(`PCCS_TDP_OFS, rd);
    check(rd, t.ns[15:0]);
    wr(`PCCS_CTL_OFS, 16'h0020);
    pccs_host_model_inst.read(`PCCS_TDP_OFS, rd);
    check(rd, t.ns[15:0]);
    pccs_host_model_inst.read(`PCCS_TDP_OFS, rd);
    check(rd, t.ns[31:16]);
    pccs_host_model_inst.read(`PCCS_TDP_OFS, rd);
    check(rd, t.sec[15:0]);
    pccs_host_model_inst.read(`PCCS_TDP_OFS, rd);
    check(rd, t.sec[31:16]);
    pccs_host_model_inst.read(`PCCS_TDP_OFS, rd);
    check(rd, 64'h0);
  endtask : test_capture

  task automatic test_run;
    logic [31:0] ns0;
    wr(`PCCS_CTL_OFS, 16'h0004);
    wr(`PCCS_CTL_OFS, 16'h0000);
    @(posedge clock_i);
    ns0 = sync_time.ns;
    @(posedge clock_i);
    check(sync_time.ns - ns0, 64'h8);
    pccs_host_model_inst.read(`PCCS_CTL_OFS, rd);
    check(rd, 64'h4);
    wr(`PCCS_CTL_OFS, 16'h0002);
    @(posedge clock_i);
    ns0 = sync_time.ns;
    @(posedge clock_i);
    check({running, sync_time.ns}, {1'b0, ns0});
    pccs_host_model_inst.read(`PCCS_CTL_OFS, rd);
    check(rd, 64'h0);
  endtask : test_run

  task automatic test_status;
    events <= '{tx_pending: 1'b1, rx_pending: 1'b0, event_pending: 1'b1, trig_fired: 1'b0, trig_notify: 1'b0};
    wr(`PCCS_STS_OFS, 16'hFFF8);
    repeat (2) @(posedge clock_i);
    check(irq, 64'h1);
    pccs_host_model_inst.read(`PCCS_STS_OFS, rd);
    check(rd, 64'h0908);
    // A fire without notification must leave the done flag clear
    @(posedge clock_i);
    events <= '{tx_pending: 1'b0, rx_pending: 1'b1, event_pending: 1'b0, trig_fired: 1'b1, trig_notify: 1'b0};
    @(posedge clock_i);
    events.trig_fired <= 1'b0;
    pccs_host_model_inst.read(`PCCS_STS_OFS, rd);
    check(rd, 64'h0408);
    check(irq, 64'h0);
    @(posedge clock_i);
    events <= '{tx_pending: 1'b0, rx_pending: 1'b0, event_pending: 1'b0, trig_fired: 1'b1, trig_notify: 1'b1};
    @(posedge clock_i);
    events.trig_fired <= 1'b0;
    wr(`PCCS_STS_OFS, 16'h0002);
    repeat (2) @(posedge clock_i);
    check(irq, 64'h1);
    pccs_host_model_inst.read(`PCCS_STS_OFS, rd);
    check(rd, 64'h0202);
    pccs_host_model_inst.read(`PCCS_STS_OFS, rd);
    check(rd, 64'h0002);
  endtask : test_status

  task automatic test_soft_reset;
    wr(`PCCS_CTL_OFS, 16'h0004);
    wr(`PCCS_CTL_OFS, 16'h0001);
    repeat (2) @(posedge clock_i);
    check({logic_reset, running, irq, sync_time}, {3'b100, 64'h0});
    repeat (10) @(posedge clock_i);
    pccs_host_model_inst.read(`PCCS_CTL_OFS, rd);
    check(rd, 64'h1);
    pccs_host_model_inst.read(`PCCS_STS_OFS, rd);
    check(rd, 64'h0);
    wr(`PCCS_CTL_OFS, 16'h0000);
    @(posedge clock_i);
    check(logic_reset, 64'h0);
  endtask : test_soft_reset

  task automatic results;
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  // A run needs well under a thousand cycles; the ceiling leaves wide margin
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      results();
    end
  end

  initial
  begin
    repeat (4) @(posedge clock_i);
    reset_i <= 1'b0;
    test_reset_state();
    test_load();
    test_step();
    test_capture();
    test_run();
    test_status();
    test_soft_reset();
    results();
  end
endmodule : pccs_regs_bench
